// file: pbcsc_pkg.sv
// Constants, carriers and the control summary of the PLL base clock select block
// ----------------------------------------------------------------------------
// Overview of operation
// - Zero reference divider or multiplier acts as one
// - Zero linear multiplier disables PLL, forces oscillator
// - Switchover waits three old edges (none from a stopped VCO), three new edges
// - Selected source halved for even duty
// - Bypass bit skips halving on oscillator path
// - Select one picks VCO path, zero oscillator
// - Select cannot be set while PLL off
// - PLL cannot be turned off while selected
// - Power and select never change together
// - Irq enable writable only under self control
// - Settled toggle sets flag; flag and enable interrupt
// - Flag reads zero without self control; reset clears
// - Reading control register clears the flag
// - Power bit enables PLL, set by reset
// - Reset clears select, oscillator drives output
// - Prescale bits writable only while PLL off
// - Prescale code gives multiplier one to eight
// - Output: oscillator, oscillator halved or VCO halved
// - Range exponent writable only while PLL off
// - Self control bit: one automatic, zero manual
// - Settled indicator reads zero without self control
// ----------------------------------------------------------------------------
package pbcsc_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam int unsigned PBCSC_AW        = 3;
  localparam int unsigned PBCSC_DW        = 8;
  localparam logic [2:0]  OFF_PLL_CONTROL = 3'h0;
  localparam logic [2:0]  OFF_BW_CONTROL  = 3'h1;
  localparam logic [2:0]  OFF_OPTION      = 3'h2;
  localparam logic [2:0]  OFF_REF_DIV     = 3'h3;
  localparam logic [2:0]  OFF_MULT_HI     = 3'h4;
  localparam logic [2:0]  OFF_MULT_LO     = 3'h5;
  localparam logic [2:0]  OFF_VCO_LIN     = 3'h6;

  // Field positions outside the control register
  localparam int unsigned BIT_SELF_CTL    = 7;
  localparam int unsigned BIT_SETTLED     = 6;
  localparam int unsigned BIT_BYPASS      = 0;

  // Reset values
  localparam logic [7:0]  RST_PLL_CONTROL = 8'h20;
  localparam logic [3:0]  RST_REF_DIV     = 4'h1;
  localparam logic [11:0] RST_MULT        = 12'h040;
  localparam logic [7:0]  RST_VCO_LIN     = 8'h40;

  // Edges counted on each side of a switchover, minus one
  localparam logic [1:0]  SW_LAST_EDGE    = 2'h2;

  // ----------------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------------
  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic       lock_irq_enable;
    logic       lock_change_flag;
    logic       pll_power_on;
    logic       base_clk_select;
    logic [1:0] prescale_select;
    logic [1:0] vco_range_exp;
  } pbcsc_ctl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } pbcsc_clkev_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRAIN = 2'b01,
    ST_FILL  = 2'b10
  } pbcsc_sw_st_t;

endpackage : pbcsc_pkg

// file: pbcsc_edge.sv
// Rise and fall detector for a source clock sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module pbcsc_edge
  import pbcsc_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          level_in,
  output var  pbcsc_clkev_t  ev
);

  typedef struct packed {
    logic         prev;
    pbcsc_clkev_t ev;
  } pbcsc_edge_st_t;

  pbcsc_edge_st_t st_ff;
  pbcsc_edge_st_t nxt_st;

  // Compare the level with last cycle's sample
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.prev    = level_in;
    nxt_st.ev.rise = level_in & ~st_ff.prev;
    nxt_st.ev.fall = ~level_in & st_ff.prev;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign ev = st_ff.ev;

endmodule : pbcsc_edge
`default_nettype wire

// file: pbcsc_lock.sv
// Frequency settled indicator with its toggle detector
`timescale 1ns/1ps
`default_nettype none
module pbcsc_lock
  import pbcsc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic bw_self_ctl,
  input  wire logic freq_settled,
  output var  logic settled,
  output var  logic toggled
);

  typedef struct packed {
    logic settled;
    logic toggled;
  } pbcsc_lock_st_t;

  pbcsc_lock_st_t st_ff;
  pbcsc_lock_st_t nxt_st;

  // Indicator is masked in manual mode; a toggle is any change of it
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.settled = bw_self_ctl & freq_settled;
    nxt_st.toggled = nxt_st.settled ^ st_ff.settled;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign settled = st_ff.settled;
  assign toggled = st_ff.toggled;

endmodule : pbcsc_lock
`default_nettype wire

// file: pbcsc_top.sv
// Base clock selector, transition control and PLL control registers
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pbcsc_top
  import pbcsc_pkg::*;
#(
  parameter int unsigned AW = PBCSC_AW,
  parameter int unsigned DW = PBCSC_DW
)
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output var  logic [DW-1:0] rdata,
  input  wire logic          osc_clock,
  input  wire logic          divided_vco_clock,
  input  wire logic          freq_settled,
  output var  logic          base_clock_out,
  output var  logic          pll_irq,
  output var  logic          pll_enable,
  output var  logic [1:0]    prescale_select,
  output var  logic [1:0]    vco_range_exp,
  output var  logic [3:0]    ref_div_eff,
  output var  logic [11:0]   fb_mult_eff,
  output var  logic [7:0]    vco_lin_mult
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    pbcsc_ctl_t   ctl;
    logic         bw_self_ctl;
    logic         osc_halving_bypass;
    logic [3:0]   ref_div;
    logic [11:0]  fb_mult;
    logic [7:0]   vco_lin;
    logic [DW-1:0] rdata;
    logic         irq;
    logic         pll_en;
    logic [3:0]   ref_div_eff;
    logic [11:0]  fb_mult_eff;
    pbcsc_sw_st_t sw;
    logic [1:0]   edge_cnt;
    logic         act_select;
    logic         base;
  } pbcsc_top_st_t;

  pbcsc_top_st_t st_ff;
  pbcsc_top_st_t nxt_st;
  pbcsc_clkev_t  osc_ev;
  pbcsc_clkev_t  vco_ev;
  logic          settled;
  logic          settled_tog;

  // Zero in a divider setting means divide by one
  function automatic logic [11:0] fix_zero(input logic [11:0] v);
    fix_zero = (v == 12'h000) ? 12'h001 : v;
  endfunction : fix_zero

  // ----------------------------------------------------------------------------
  // Source clock edges and settled indicator
  // ----------------------------------------------------------------------------
  pbcsc_edge u_osc_edge (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .level_in (osc_clock),
    .ev       (osc_ev)
  );

  pbcsc_edge u_vco_edge (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .level_in (divided_vco_clock),
    .ev       (vco_ev)
  );

  pbcsc_lock u_lock (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .bw_self_ctl  (st_ff.bw_self_ctl),
    .freq_settled (freq_settled),
    .settled      (settled),
    .toggled      (settled_tog)
  );

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    pbcsc_ctl_t w;
    logic       wr_ctl;
    logic       rd_ctl;
    logic       sel_moves;
    logic       lin_zero;
    logic       old_rise;
    logic       new_rise;
    logic [11:0] rdiv_fix;
    nxt_st    = st_ff;
    rdiv_fix  = 12'h000;
    w         = pbcsc_ctl_t'(wdata);
    wr_ctl    = wr_en && (addr == OFF_PLL_CONTROL);
    rd_ctl    = rd_en && (addr == OFF_PLL_CONTROL);
    sel_moves = 1'b0;
    lin_zero  = (st_ff.vco_lin == 8'h00);
    old_rise  = st_ff.act_select ? vco_ev.rise : osc_ev.rise;
    new_rise  = st_ff.act_select ? osc_ev.rise : vco_ev.rise;

    // Control register write with its interlocks
    if (wr_ctl)
    begin
      if (w.base_clk_select != st_ff.ctl.base_clk_select)
      begin
        // Setting needs the PLL on and a usable linear multiplier
        if (!w.base_clk_select || (st_ff.ctl.pll_power_on && !lin_zero))
        begin
          nxt_st.ctl.base_clk_select = w.base_clk_select;
          sel_moves                  = 1'b1;
        end
      end
      // Power may not move in the same write as the select
      if ((w.pll_power_on != st_ff.ctl.pll_power_on) && !sel_moves &&
          !(st_ff.ctl.base_clk_select && !w.pll_power_on))
        nxt_st.ctl.pll_power_on = w.pll_power_on;
      if (st_ff.bw_self_ctl)
        nxt_st.ctl.lock_irq_enable = w.lock_irq_enable;
      if (!st_ff.ctl.pll_power_on)
      begin
        nxt_st.ctl.prescale_select = w.prescale_select;
        nxt_st.ctl.vco_range_exp   = w.vco_range_exp;
      end
    end

    // Other registers; divider settings frozen while the PLL runs
    if (wr_en)
    begin
      unique case (addr)
        OFF_BW_CONTROL:
          nxt_st.bw_self_ctl = wdata[BIT_SELF_CTL];
        OFF_OPTION:
          nxt_st.osc_halving_bypass = wdata[BIT_BYPASS];
        OFF_REF_DIV:
          if (!st_ff.ctl.pll_power_on)
            nxt_st.ref_div = wdata[3:0];
        OFF_MULT_HI:
          if (!st_ff.ctl.pll_power_on)
            nxt_st.fb_mult[11:8] = wdata[3:0];
        OFF_MULT_LO:
          if (!st_ff.ctl.pll_power_on)
            nxt_st.fb_mult[7:0] = wdata[7:0];
        OFF_VCO_LIN:
          if (!st_ff.ctl.pll_power_on)
            nxt_st.vco_lin = wdata[7:0];
        default:
          nxt_st.rdata = st_ff.rdata;
      endcase
    end

    // Zero linear multiplier: oscillator forced, PLL held off
    if (nxt_st.vco_lin == 8'h00)
      nxt_st.ctl.base_clk_select = 1'b0;
    nxt_st.pll_en = nxt_st.ctl.pll_power_on && (nxt_st.vco_lin != 8'h00);
    // Widened through the shared helper, then cut back to the divider width
    rdiv_fix           = fix_zero({8'h00, nxt_st.ref_div});
    nxt_st.ref_div_eff = rdiv_fix[3:0];
    nxt_st.fb_mult_eff = fix_zero(nxt_st.fb_mult);

    // Flag: a toggle in the clearing cycle still sets it
    nxt_st.ctl.lock_change_flag = nxt_st.bw_self_ctl &&
      ((st_ff.ctl.lock_change_flag && !rd_ctl) || settled_tog);
    nxt_st.irq = nxt_st.ctl.lock_change_flag && nxt_st.ctl.lock_irq_enable &&
                 nxt_st.bw_self_ctl;

    // Read data stand one cycle after the strobe, zero otherwise
    nxt_st.rdata = '0;
    if (rd_en)
    begin
      unique case (addr)
        OFF_PLL_CONTROL:
        begin
          nxt_st.rdata = DW'(st_ff.ctl);
          nxt_st.rdata[7] = st_ff.ctl.lock_irq_enable & st_ff.bw_self_ctl;
          nxt_st.rdata[6] = st_ff.ctl.lock_change_flag & st_ff.bw_self_ctl;
        end
        OFF_BW_CONTROL:
        begin
          nxt_st.rdata[BIT_SELF_CTL] = st_ff.bw_self_ctl;
          nxt_st.rdata[BIT_SETTLED]  = settled;
        end
        OFF_OPTION:
          nxt_st.rdata[BIT_BYPASS] = st_ff.osc_halving_bypass;
        OFF_REF_DIV:
          nxt_st.rdata[3:0] = st_ff.ref_div;
        OFF_MULT_HI:
          nxt_st.rdata[3:0] = st_ff.fb_mult[11:8];
        OFF_MULT_LO:
          nxt_st.rdata = st_ff.fb_mult[7:0];
        OFF_VCO_LIN:
          nxt_st.rdata = st_ff.vco_lin;
        default:
          nxt_st.rdata = '0;
      endcase
    end

    // Transition control: the select change is followed out on the old
    // source's own edges, then in on the new one's, with the output frozen
    unique case (st_ff.sw)
      ST_RUN:
      begin
        if (st_ff.ctl.base_clk_select != st_ff.act_select)
        begin
          nxt_st.sw       = ST_DRAIN;
          nxt_st.edge_cnt = '0;
        end
        else if (st_ff.act_select)
        begin
          if (vco_ev.rise)
            nxt_st.base = ~st_ff.base;
        end
        else if (st_ff.osc_halving_bypass)
        begin
          if (osc_ev.rise || osc_ev.fall)
            nxt_st.base = ~st_ff.base;
        end
        else if (osc_ev.rise)
          nxt_st.base = ~st_ff.base;
      end
      ST_DRAIN:
      begin
        // A stopped VCO gives no edges, so it is not waited for
        if (st_ff.act_select && !st_ff.pll_en)
        begin
          nxt_st.sw       = ST_FILL;
          nxt_st.edge_cnt = '0;
        end
        else if (old_rise)
        begin
          if (st_ff.edge_cnt == SW_LAST_EDGE)
          begin
            nxt_st.sw       = ST_FILL;
            nxt_st.edge_cnt = '0;
          end
          else
            nxt_st.edge_cnt = st_ff.edge_cnt + 2'h1;
        end
      end
      ST_FILL:
      begin
        if (new_rise)
        begin
          if (st_ff.edge_cnt == SW_LAST_EDGE)
          begin
            nxt_st.sw         = ST_RUN;
            nxt_st.act_select = ~st_ff.act_select;
            nxt_st.edge_cnt   = '0;
          end
          else
            nxt_st.edge_cnt = st_ff.edge_cnt + 2'h1;
        end
      end
      default:
        nxt_st.sw = ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // Power-on default keeps the PLL running so it settles during start-up
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_ff             <= '0;
      st_ff.ctl         <= pbcsc_ctl_t'(RST_PLL_CONTROL);
      st_ff.ref_div     <= RST_REF_DIV;
      st_ff.ref_div_eff <= RST_REF_DIV;
      st_ff.fb_mult     <= RST_MULT;
      st_ff.fb_mult_eff <= RST_MULT;
      st_ff.vco_lin     <= RST_VCO_LIN;
      st_ff.pll_en      <= 1'b1;
      st_ff.sw          <= ST_RUN;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign rdata           = st_ff.rdata;
  assign base_clock_out  = st_ff.base;
  assign pll_irq         = st_ff.irq;
  assign pll_enable      = st_ff.pll_en;
  assign prescale_select = st_ff.ctl.prescale_select;
  assign vco_range_exp   = st_ff.ctl.vco_range_exp;
  assign ref_div_eff     = st_ff.ref_div_eff;
  assign fb_mult_eff     = st_ff.fb_mult_eff;
  assign vco_lin_mult    = st_ff.vco_lin;

endmodule : pbcsc_top
`default_nettype wire

// file: pbcsc_top_props.sv
// Port checker for the base clock select block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module pbcsc_top_props
  import pbcsc_pkg::*;
#(
  parameter int unsigned AW = PBCSC_AW,
  parameter int unsigned DW = PBCSC_DW
)
(
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic          wr_en,
  input wire logic          rd_en,
  input wire logic [DW-1:0] rdata,
  input wire logic          osc_clock,
  input wire logic          divided_vco_clock,
  input wire logic          freq_settled,
  input wire logic          base_clock_out,
  input wire logic          pll_irq,
  input wire logic          pll_enable,
  input wire logic [1:0]    prescale_select,
  input wire logic [1:0]    vco_range_exp,
  input wire logic [3:0]    ref_div_eff,
  input wire logic [11:0]   fb_mult_eff,
  input wire logic [7:0]    vco_lin_mult
);
  // ----------------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------------
  logic [4:0] act_ff;
  logic       osc_d_ff;
  logic       vco_d_ff;
  logic       fs_d_ff;
  logic [3:0] quiet_ff;

  // Source activity window; held full in reset, detectors may fire on release
  always_ff @(posedge ref_clk)
  begin
    osc_d_ff <= osc_clock;
    vco_d_ff <= divided_vco_clock;
    fs_d_ff  <= freq_settled;
    if (rst)
    begin
      act_ff   <= 5'h1F;
      quiet_ff <= 4'h0;
    end
    else
    begin
      act_ff   <= {act_ff[3:0], (osc_clock ^ osc_d_ff) | (divided_vco_clock ^ vco_d_ff)};
      quiet_ff <= (freq_settled != fs_d_ff) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
    end
  end

  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_refdiv_nonzero: assert property (ref_div_eff != 4'h0)
    else $error("reference divider output is zero");
  a_mult_nonzero: assert property (fb_mult_eff != 12'h000)
    else $error("feedback multiplier output is zero");
  a_lin_zero_off: assert property ((vco_lin_mult == 8'h00) [*2] |-> !pll_enable)
    else $error("pll enabled with zero linear multiplier");
  a_pre_locked: assert property ($changed(prescale_select) |-> !$past(pll_enable))
    else $error("prescale changed while pll on");
  a_range_locked: assert property ($changed(vco_range_exp) |-> !$past(pll_enable))
    else $error("range exponent changed while pll on");
  a_base_from_src: assert property ($changed(base_clock_out) |-> act_ff != 5'h00)
    else $error("base clock moved without a source edge");
  a_irq_read_clr: assert property ((rd_en && addr == 3'h0 && quiet_ff > 4'h5) ##1
    (quiet_ff > 4'h5) [*3] |-> !pll_irq)
    else $error("interrupt still high after control read");
  a_pll_on_reset: assert property ($fell(rst) |-> pll_enable)
    else $error("pll not enabled out of reset");

  c_irq_rise: cover property ($rose(pll_irq));
  c_base_move: cover property ($changed(base_clock_out));
  c_pll_off: cover property ($fell(pll_enable));
endmodule : pbcsc_top_props

bind pbcsc_top pbcsc_top_props #(.AW(AW), .DW(DW)) pbcsc_top_props_inst (
  .ref_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .osc_clock,
  .divided_vco_clock, .freq_settled, .base_clock_out, .pll_irq, .pll_enable,
  .prescale_select, .vco_range_exp, .ref_div_eff, .fb_mult_eff, .vco_lin_mult
);
`default_nettype wire

// file: pbcsc_siu_model.sv
// Far side model: source clocks, lock indicator and base clock timing monitor
`timescale 1ns/1ps
`default_nettype none
module pbcsc_siu_model
  import pbcsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        pll_enable,
  input  wire logic        base_clock_out,
  input  wire logic        settle_req,
  output var  logic        osc_clock,
  output var  logic        divided_vco_clock,
  output var  logic        freq_settled,
  output var  logic [15:0] half_len,
  output var  logic [15:0] n_edges
);
  localparam int OSC_HALF = 4;
  localparam int VCO_HALF = 3;
  int          oc;
  int          vc;
  logic [15:0] run;
  logic        bd;

  // Oscillator runs free; the VCO stands still while the pll is disabled
  initial
  begin
    osc_clock = 1'b0;
    divided_vco_clock = 1'b0;
    freq_settled = 1'b0;
    half_len = 16'h0000;
    n_edges = 16'h0000;
    oc = 0;
    vc = 0;
    run = 16'h0000;
    bd = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      oc = (oc == OSC_HALF - 1) ? 0 : oc + 1;
      if (oc == 0)
        osc_clock <= ~osc_clock;
      if (pll_enable === 1'b1)
        vc = (vc == VCO_HALF - 1) ? 0 : vc + 1;
      if (pll_enable === 1'b1 && vc == 0)
        divided_vco_clock <= ~divided_vco_clock;
      freq_settled <= settle_req;
      // Each base level is timed in system cycles, so duty is seen per half
      run = run + 16'h0001;
      if (base_clock_out !== bd)
      begin
        bd = base_clock_out;
        half_len <= run;
        n_edges <= n_edges + 16'h0001;
        run = 16'h0000;
      end
    end
  end
endmodule : pbcsc_siu_model
`default_nettype wire

// file: tb_pbcsc_top.sv
// Self-checking testbench for the base clock select block
`timescale 1ns/1ps
`default_nettype none
module tb_pbcsc_top
  import pbcsc_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        settle_req = 1'b0;
  logic [7:0]  rdata;
  logic        osc_clock;
  logic        divided_vco_clock;
  logic        freq_settled;
  logic        base_clock_out;
  logic        pll_irq;
  logic        pll_enable;
  logic [1:0]  prescale_select;
  logic [1:0]  vco_range_exp;
  logic [3:0]  ref_div_eff;
  logic [11:0] fb_mult_eff;
  logic [7:0]  vco_lin_mult;
  logic [15:0] half_len;
  logic [15:0] n_edges;
  int          miscompares = 0;
  int          n_checks = 0;

  always #2 ref_clk = ~ref_clk;

  pbcsc_top pbcsc_top_inst (.ref_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .osc_clock, .divided_vco_clock, .freq_settled, .base_clock_out, .pll_irq,
    .pll_enable, .prescale_select, .vco_range_exp, .ref_div_eff, .fb_mult_eff,
    .vco_lin_mult);
  pbcsc_siu_model pbcsc_siu_model_inst (.ref_clk, .pll_enable, .base_clock_out,
    .settle_req, .osc_clock, .divided_vco_clock, .freq_settled, .half_len, .n_edges);

  // ----------------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(name, {8'h00, rdata}, {8'h00, exp});
  endtask : rchk

  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : waitc

  // Bounded wait for the next base clock level change
  task automatic next_edge();
    logic [15:0] e;
    int          k;
    e = n_edges;
    k = 0;
    while (n_edges === e && k < 200)
    begin
      @(posedge ref_clk);
      k++;
    end
    #1;
    chk("base edge wait", 16'(k < 200), 16'h0001);
  endtask : next_edge

  // Third half is timed so a half cut by a mode change is skipped
  task automatic meas(input logic [15:0] exp);
    next_edge();
    next_edge();
    next_edge();
    chk("base half period", half_len, exp);
  endtask : meas

  // ----------------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    #160000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(3'h0, 8'h20, "control reset");
    rchk(3'h1, 8'h00, "bw reset");
    rchk(3'h7, 8'h00, "unmapped");
    chk("fb mult reset", 16'(fb_mult_eff), 16'h0040);
    // Oscillator path halved, bypassed, then switched to the vco path
    meas(16'h0008);
    wr(3'h2, 8'h01);
    meas(16'h0004);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h30);
    waitc(4);
    next_edge();
    chk("switch gap", 16'(half_len >= 16'h0010 && half_len <= 16'h0048), 16'h0001);
    meas(16'h0006);
    // Power and select interlocks
    wr(3'h0, 8'h10);
    rchk(3'h0, 8'h30, "power off refused");
    wr(3'h0, 8'h00);
    rchk(3'h0, 8'h20, "power and select together");
    wr(3'h0, 8'h00);
    rchk(3'h0, 8'h00, "power off");
    chk("pll_enable off", 16'(pll_enable), 16'h0000);
    wr(3'h0, 8'h30);
    rchk(3'h0, 8'h20, "select while off");
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    waitc(2);
    chk("ref div zero", 16'(ref_div_eff), 16'h0001);
    chk("fb mult zero", 16'(fb_mult_eff), 16'h0001);
    for (int p = 0; p < 4; p++)
    begin
      wr(3'h0, {4'h0, 2'(p), 2'b10});
      waitc(2);
      chk("prescale", 16'(prescale_select), 16'(p));
      chk("range exp", 16'(vco_range_exp), 16'h0002);
    end
    wr(3'h6, 8'h00);
    wr(3'h0, 8'h2E);
    waitc(2);
    chk("pll_enable lin zero", 16'(pll_enable), 16'h0000);
    chk("lin mult zero", 16'(vco_lin_mult), 16'h0000);
    wr(3'h0, 8'h3E);
    rchk(3'h0, 8'h2E, "select lin zero");
    wr(3'h0, 8'h21);
    rchk(3'h0, 8'h2E, "fields locked");
    wr(3'h0, 8'h0E);
    wr(3'h6, 8'h40);
    wr(3'h0, 8'h20);
    waitc(2);
    chk("pll_enable on", 16'(pll_enable), 16'h0001);
    // Lock change flag and interrupt
    wr(3'h0, 8'hA0);
    rchk(3'h0, 8'h20, "irq enable manual");
    @(posedge ref_clk);
    settle_req <= 1'b1;
    waitc(6);
    rchk(3'h0, 8'h20, "flag manual");
    wr(3'h1, 8'h80);
    waitc(5);
    rchk(3'h1, 8'hC0, "settled auto");
    rchk(3'h0, 8'h60, "flag on settle");
    rchk(3'h0, 8'h20, "flag read clear");
    wr(3'h0, 8'hA0);
    rchk(3'h0, 8'hA0, "irq enable auto");
    chk("irq idle", 16'(pll_irq), 16'h0000);
    @(posedge ref_clk);
    settle_req <= 1'b0;
    waitc(5);
    chk("irq raised", 16'(pll_irq), 16'h0001);
    waitc(8);
    chk("irq held", 16'(pll_irq), 16'h0001);
    rchk(3'h0, 8'hE0, "flag and enable");
    waitc(3);
    chk("irq cleared", 16'(pll_irq), 16'h0000);
    rchk(3'h0, 8'hA0, "flag cleared");
    wr(3'h1, 8'h00);
    rchk(3'h0, 8'h20, "manual again");
    // Reset in mid-run
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(3'h0, 8'h20, "control second reset");
    rchk(3'h6, 8'h40, "lin second reset");
    rchk(3'h3, 8'h01, "ref div second reset");
    end_of_test();
  end
endmodule : tb_pbcsc_top
`default_nettype wire
